// ===== hdl/hpb_params.svh
`ifndef HPB_PARAMS_SVH
`define HPB_PARAMS_SVH

// =====================================================================
// Line acquisition mode codes
`define HPB_MODE_SINGLE      3'h0
`define HPB_MODE_VBIN        3'h1
`define HPB_MODE_AVG         3'h2
`define HPB_MODE_TD_SUM_A    3'h3
`define HPB_MODE_TD_SUM_B    3'h4
`define HPB_MODE_TD_AVG_A    3'h5
`define HPB_MODE_TD_AVG_B    3'h6

// =====================================================================
// Binning mode field codes
`define HPB_BIN_OFF          1'h0
`define HPB_BIN_ON           1'h1

// =====================================================================
// Sizes and reset values
`define HPB_PIX_W            10
`define HPB_LINE_LEN         4096
`define HPB_FIFO_DEPTH       16
`define HPB_RST_MODE         3'h0
`define HPB_RST_BIN          1'h0

`endif

// ===== hdl/hpb_pkg.sv
package hpb_pkg;
  `include "hpb_params.svh"

  // Sensor pixel pair, one from each line, same column
  typedef struct packed {
    logic [`HPB_PIX_W-1:0] pix_a;
    logic [`HPB_PIX_W-1:0] pix_b;
    logic                  sol;
    logic                  eol;
  } hpb_in_s;

  // Output word: room for sum of four pixels
  typedef struct packed {
    logic [`HPB_PIX_W+1:0] pix;
    logic                  sol;
    logic                  eol;
  } hpb_out_s;

  typedef enum logic [1:0] {
    ST_EVEN = 2'b01,
    ST_ODD  = 2'b10
  } hpb_state_e;
endpackage

// ===== hdl/hpb_fifo.sv
`timescale 1ns/10ps
module hpb_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Handshake: honest full and empty
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_q];

  // Storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== hdl/hpb_core.sv
`timescale 1ns/10ps
`include "hpb_params.svh"
module hpb_core
  import hpb_pkg::*;
#(
  parameter int LINE_LEN   = `HPB_LINE_LEN,
  parameter int FIFO_DEPTH = `HPB_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Control status register fields
  input  wire logic [2:0]  line_mode,
  input  wire logic        bin_mode,
  // Sensor readout stream
  input  wire logic        pix_valid,
  output logic             pix_ready,
  input  wire hpb_in_s     pix_in,
  // Output link stream
  output logic             out_valid,
  input  wire logic        out_ready,
  output hpb_out_s         out_data,
  // Status
  output logic             bin_active
);
  localparam int PW = `HPB_PIX_W;
  localparam int AW = $clog2(LINE_LEN);
  localparam int OW = PW + 2;

  // =====================================================================
  // Helpers

  // Halve with round-up, as averaging modes demand
  function automatic logic [PW:0] avg_up(input logic [PW:0] s);
    avg_up = (s + (PW+1)'(1)) >> 1;
  endfunction

  // Widened add of two words, never wraps
  function automatic logic [OW-1:0] wadd(input logic [OW-1:0] a, input logic [OW-1:0] b);
    wadd = a + b;
  endfunction

  // =====================================================================
  // Control registers, sampled from the control status register fields
  logic [2:0] mode_q;
  logic       bin_q;
  logic [2:0] mode_w;
  logic       bin_w;
  hpb_state_e state_q;

  // Mode changes only take effect at a line start so lines stay whole
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode_q <= `HPB_RST_MODE;
      bin_q  <= `HPB_RST_BIN;
    end
    else if (pix_valid && pix_ready && pix_in.sol)
    begin
      mode_q <= line_mode;
      bin_q  <= (bin_mode == `HPB_BIN_ON);
    end
  end

  assign bin_active = bin_q;

  // A line's first pixel already obeys the fields it arrives with, else it would
  // be combined and paired under the previous line's settings
  assign mode_w = (pix_valid && pix_in.sol) ? line_mode : mode_q;
  assign bin_w  = (pix_valid && pix_in.sol) ? (bin_mode == `HPB_BIN_ON) : bin_q;

  // =====================================================================
  // Delay line buffer for time delayed modes
  logic [PW-1:0] dly_mem [LINE_LEN];
  logic [AW-1:0] col_q;
  logic [PW-1:0] dly_rd;
  logic          delayed_b;
  logic          td_mode;
  logic          take;
  logic          dly_primed_q;

  assign take      = pix_valid & pix_ready;
  assign td_mode   = (mode_w == `HPB_MODE_TD_SUM_A) || (mode_w == `HPB_MODE_TD_SUM_B) ||
                     (mode_w == `HPB_MODE_TD_AVG_A) || (mode_w == `HPB_MODE_TD_AVG_B);
  assign delayed_b = (mode_w == `HPB_MODE_TD_SUM_B) || (mode_w == `HPB_MODE_TD_AVG_B);
  assign dly_rd    = dly_primed_q ? dly_mem[col_q] : '0;

  // First delayed line has no earlier line to add: it reads zero, not stale memory.
  // Limitation: a short first delayed line primes only the columns it carried.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dly_primed_q <= 1'b0;
    end
    else if (take && td_mode && pix_in.eol)
    begin
      dly_primed_q <= 1'b1;
    end
  end

  // Store the delayed line, read back the previous acquisition's pixel
  always_ff @(posedge clk_sys)
  begin
    if (take && td_mode)
    begin
      dly_mem[col_q] <= delayed_b ? pix_in.pix_b : pix_in.pix_a;
    end
  end

  // Column counter
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      col_q <= '0;
    end
    else if (take)
    begin
      col_q <= (pix_in.eol || col_q == AW'(LINE_LEN-1)) ? '0 : col_q + AW'(1);
    end
  end

  // =====================================================================
  // Per-column line combine
  logic [OW-1:0] col_val;
  logic [PW:0]   raw_sum;

  // Combine per acquisition mode, widened so nothing wraps
  always_comb
  begin
    raw_sum = '0;
    col_val = '0;
    case (mode_w)
      `HPB_MODE_SINGLE:
        col_val = OW'(pix_in.pix_a);
      `HPB_MODE_VBIN:
        col_val = OW'({1'b0, pix_in.pix_a} + {1'b0, pix_in.pix_b});
      `HPB_MODE_AVG:
      begin
        raw_sum = {1'b0, pix_in.pix_a} + {1'b0, pix_in.pix_b};
        col_val = OW'(avg_up(raw_sum));
      end
      `HPB_MODE_TD_SUM_A:
        col_val = OW'({1'b0, dly_rd} + {1'b0, pix_in.pix_b});
      `HPB_MODE_TD_SUM_B:
        col_val = OW'({1'b0, dly_rd} + {1'b0, pix_in.pix_a});
      `HPB_MODE_TD_AVG_A:
      begin
        raw_sum = {1'b0, dly_rd} + {1'b0, pix_in.pix_b};
        col_val = OW'(avg_up(raw_sum));
      end
      `HPB_MODE_TD_AVG_B:
      begin
        raw_sum = {1'b0, dly_rd} + {1'b0, pix_in.pix_a};
        col_val = OW'(avg_up(raw_sum));
      end
      default:
        col_val = OW'(pix_in.pix_a);
    endcase
  end

  // =====================================================================
  // Horizontal pair binning
  logic [OW-1:0] hold_q;
  logic          hold_sol_q;
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  hpb_out_s      fifo_in;

  // Pair state: even column held, odd column completes the pair
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q    <= ST_EVEN;
      hold_q     <= '0;
      hold_sol_q <= 1'b0;
    end
    else if (take)
    begin
      case (state_q)
        ST_EVEN:
        begin
          if (bin_w && !pix_in.eol)
          begin
            hold_q     <= col_val;
            hold_sol_q <= pix_in.sol;
            state_q    <= ST_ODD;
          end
        end
        ST_ODD:
          state_q <= ST_EVEN;
        default:
          state_q <= ST_EVEN;
      endcase
    end
  end

  // Emit on the odd pixel; an odd lone last pixel passes unbinned
  always_comb
  begin
    fifo_in_valid = 1'b0;
    fifo_in       = '0;
    if (!bin_w || state_q == ST_EVEN)
    begin
      fifo_in_valid = pix_valid && !(bin_w && !pix_in.eol);
      fifo_in.pix   = col_val;
      fifo_in.sol   = pix_in.sol;
      fifo_in.eol   = pix_in.eol;
    end
    else
    begin
      fifo_in_valid = pix_valid;
      fifo_in.pix   = wadd(hold_q, col_val);
      fifo_in.sol   = hold_sol_q;
      fifo_in.eol   = pix_in.eol;
    end
  end

  // Held pixels need no FIFO space; others stall on back-pressure
  assign pix_ready = fifo_in_valid ? fifo_in_ready : 1'b1;

  // =====================================================================
  // Output buffer toward the link
  logic [OW+1:0] fifo_out_w;

  hpb_fifo #(
    .WIDTH (OW + 2),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out_w)
  );

  assign out_data = fifo_out_w;
endmodule

// ===== testbench/hpb_core_sva.sv
`timescale 1ns/10ps
module hpb_core_sva
  import hpb_pkg::*;
#(
  parameter int LINE_LEN   = 8,
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset, mode fields
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [2:0] line_mode,
  input wire logic       bin_mode,
  // Streams and status
  input wire logic       pix_valid,
  input wire logic       pix_ready,
  input wire hpb_in_s    pix_in,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire hpb_out_s   out_data,
  input wire logic       bin_active
);
  // ==========
  // Stream checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire take = pix_valid && pix_ready;
  a_reset_idle: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |=> !out_valid && pix_ready && !bin_active) else $error("bad reset state");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("word dropped");
  a_bin_follow: assert property (
    take && pix_in.sol |=> bin_active == $past(bin_mode)) else $error("bin state stale");
  a_pair_done: assert property (
    take && bin_active && pix_in.eol && !pix_in.sol |=> out_valid) else $error("pair late");
  a_plain_word: assert property (
    take && !bin_active && !pix_in.sol |=> out_valid) else $error("word late");
  a_sum_range: assert property (
    out_valid |-> out_data.pix <= 12'hffc) else $error("sum too large");
  a_pop_frees: assert property (
    out_valid && out_ready |=> pix_ready) else $error("refused after pop");
  a_no_phantom: assert property (
    !out_valid && !take |=> !out_valid) else $error("word from nothing");
endmodule

bind hpb_core hpb_core_sva #(.LINE_LEN(LINE_LEN), .FIFO_DEPTH(FIFO_DEPTH)) i_sva (
  .clk_sys(clk_sys), .reset(reset), .line_mode(line_mode), .bin_mode(bin_mode),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_in(pix_in), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data), .bin_active(bin_active));

// ===== testbench/hpb_sink.sv
`timescale 1ns/10ps
module hpb_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Stall controls
  input wire logic hold,
  input wire logic slow,
  // Output link
  input wire logic out_valid,
  output logic     out_ready
);
  logic [1:0] cnt_q;
  // ==========
  // Link takes one word in three when slow, none while held
  always_ff @(posedge clk_sys)
  begin
    cnt_q <= (reset || cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
    out_ready <= !reset && !hold && (!slow || cnt_q == 2'h0);
  end
endmodule

// ===== testbench/horizontal_pixel_binning_bench.sv
`timescale 1ns/10ps
`include "hpb_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module horizontal_pixel_binning_bench;
  import hpb_pkg::*;
  logic       clk_sys = 0, reset = 1, pix_valid = 0, bin_mode = 0, hold = 0, slow = 0;
  logic [2:0] line_mode = 3'h0;
  hpb_in_s    pix_in = '0;
  logic       pix_ready, out_valid, out_ready, bin_active;
  hpb_out_s   out_data, e;
  hpb_out_s   exp_q[$];
  int         failures = 0, n_tests = 0, cycles = 0;
  logic [31:0] rng = 32'h8fc3;
  localparam int LL = 8;
  logic [9:0] dly_m [LL] = '{default: 10'h0}; // Bench copy of the delayed line

  hpb_core #(.LINE_LEN(LL), .FIFO_DEPTH(16)) i_dut (.clk_sys(clk_sys), .reset(reset),
    .line_mode(line_mode), .bin_mode(bin_mode), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_in(pix_in), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .bin_active(bin_active));
  hpb_sink i_sink (.clk_sys(clk_sys), .reset(reset), .hold(hold), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready));

  // ==========
  // Clock, hang guard, verdict
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected combine of one column before pairing; averages round up
  function automatic logic [11:0] col_exp(input logic [2:0] m, input logic [9:0] a,
                                          input logic [9:0] bb, input logic [9:0] d);
    logic [10:0] s;
    s = 11'(a);
    if (m == `HPB_MODE_VBIN || m == `HPB_MODE_AVG) s = a + bb;
    if (m == `HPB_MODE_TD_SUM_A || m == `HPB_MODE_TD_AVG_A) s = d + bb;
    if (m == `HPB_MODE_TD_SUM_B || m == `HPB_MODE_TD_AVG_B) s = d + a;
    if (m == `HPB_MODE_AVG || m == `HPB_MODE_TD_AVG_A || m == `HPB_MODE_TD_AVG_B)
      s = (s + 11'h1) >> 1;
    return 12'(s);
  endfunction

  // One line from the sensor; expected words noted as they complete
  task automatic send_line(input logic [2:0] m, input logic b, input int len, input logic mx);
    logic [9:0]  a, bb, d;
    logic [11:0] acc;
    line_mode = m;
    bin_mode = b;
    acc = '0;
    for (int c = 0; c < len; c++)
    begin
      rng = xs(rng);
      a = mx ? 10'h3ff : rng[9:0];
      bb = mx ? 10'h3ff : rng[25:16];
      pix_in = '{a, bb, c == 0, c == len - 1};
      pix_valid = 1; // Offer this column's pixel pair until it is taken
      d = dly_m[c % LL];
      if (m >= `HPB_MODE_TD_SUM_A && m <= `HPB_MODE_TD_AVG_B)
        dly_m[c % LL] = (m == `HPB_MODE_TD_SUM_B || m == `HPB_MODE_TD_AVG_B) ? bb : a;
      acc = acc + col_exp(m, a, bb, d);
      if (!b || c[0] || c == len - 1)
      begin
        exp_q.push_back('{acc, (b ? c <= 1 : c == 0), c == len - 1});
        acc = '0;
      end
      #1;
      while (pix_ready !== 1'b1) @(posedge clk_sys) #2;
      @(posedge clk_sys) #1;
    end
    pix_valid = 0;
    @(posedge clk_sys) #1; // Idle edge, so valid never falls and rises in one step
  endtask

  // Scoreboard: settled at the falling edge, taken at the next rise
  always @(negedge clk_sys)
    if (!reset && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_q.size() == 0) `CHK("extra word", 1'b0, 1'b1)
      else
      begin
        e = exp_q.pop_front();
        `CHK("pix", e.pix, out_data.pix)
        `CHK("sol eol", {e.sol, e.eol}, {out_data.sol, out_data.eol})
      end
    end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1 reset = 0;
    `CHK("bin after reset", 1'b0, bin_active)
    for (int m = 0; m < 7; m++)
      for (int b = 0; b < 2; b++) send_line(m[2:0], b[0], 8, 1'b0);
    `CHK("bin state", 1'b1, bin_active)
    send_line(3'h0, 1'b1, 5, 1'b0);
    send_line(3'h1, 1'b1, 8, 1'b1);
    hold = 1;
    // Fill until refused, then let the link drain
    fork
      send_line(3'h1, 1'b0, 24, 1'b0);
      begin
        repeat (30) @(posedge clk_sys);
        #2 `CHK("full refuse", 1'b0, pix_ready)
        hold = 0;
      end
    join
    slow = 1;
    send_line(3'h0, 1'b1, 16, 1'b0);
    repeat (300) if (exp_q.size() != 0) @(posedge clk_sys);
    `CHK("words left", 0, exp_q.size())
    @(posedge clk_sys) #1;
    slow = 0;
    hold = 1;
    send_line(3'h0, 1'b0, 3, 1'b0);
    reset = 1;
    exp_q.delete();
    dly_m = '{default: 10'h0};
    repeat (2) @(posedge clk_sys);
    #1 reset = 0;
    hold = 0;
    `CHK("flushed", 1'b0, out_valid)
    // Recovery after a mid-run reset: averaged, binned line
    send_line(3'h2, 1'b1, 4, 1'b0);
    repeat (50) if (exp_q.size() != 0) @(posedge clk_sys);
    `CHK("words after reset", 0, exp_q.size())
    conclude();
  end
endmodule
